// [design/exc_ctrl.sv]
// Purpose: exception state tracking, priority arbitration, preemption and vectors
// Assumes: sources and pipeline on clk, software over AXI4-Lite
// Notes:   overview of operation below
// Overview of operation
// - each exception is inactive, pending, active, or active and pending
// - a peripheral line or software set request pends the interrupt
// - reset halts the core, then restarts privileged thread at reset vector
// - nmi is always enabled at -2, only reset outranks it
// - errors during entry or unhandled faults raise hard fault at -1
// - execute-never or protection violation raises memory management fault
// - bus errors raise bus fault, precise or imprecise
// - usage fault for bad instructions; unaligned and div-zero when configured
// - supervisor call instruction raises exception 11 synchronously
// - system tick pends on timer zero or software request
// - word 0 is initial stack pointer, handler at four times number
// - one more instruction may finish before an asynchronous entry
// - software may disable configurable exceptions, fixed ones never
// - peripheral lines 0 to 67 use vectors after system ones
// - table base zero after reset, relocatable 0x80 to 0x3fffff80
// - lower value is more urgent; all but three are configurable
// - configurable priorities reset to zero
// - configurable priorities are 0 to 15
// - equal priority pending: lowest number first
// - only strictly more urgent exception preempts; equal only pends
// - group field decides preemption, subpriority then number orders
`timescale 1ns/1ps
module exc_ctrl (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  input  wire logic [exc_pkg::NUM_IRQ-1:0] irq_lines,
  input  wire logic                       nmi_req,
  input  wire logic                       systick_zero,
  input  wire exc_pkg::fault_in_t         faults,
  input  wire logic                       entry_ack,
  input  wire logic                       return_valid,
  input  wire logic [6:0]                 return_num,
  output exc_pkg::pipe_out_t              pipe,
  output logic                            halt,
  output logic                            thread_priv,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [exc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic [1:0]                      bresp,
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [exc_pkg::ADDR_W-1:0] araddr,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp
);
  import exc_pkg::*;

  logic [NUM_EXC-1:0] pend_r, act_r, en_r, set_v, clr_v, ret_v, ack_v;
  logic [3:0]         prio_r [NUM_EXC];
  logic [31:0]        tbase_r;
  logic [4:0]         cfg_r;
  logic [6:0]         sel_r, win_num;
  logic               halt_r, win_found, preempt, any_act;
  logic signed [5:0]  best, cur_grp, win_grp, e;
  pipe_out_t          pipe_r;
  logic               aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [7:0]         awaddr_r;
  logic [31:0]        wdata_r, rdata_r;
  logic [3:0]         wstrb_r;
  logic [1:0]         bresp_r, rresp_r;
  logic               wr_fire, wr_ok, mm_raise, bus_raise, us_raise;

  ////////////////////////////////////////////////////////////////////////////
  // priority helpers
  function automatic logic signed [5:0] eff_of(input int n, input logic [3:0] p);
    if (n == int'(EXC_RESET)) return PRIO_RESET;
    if (n == int'(EXC_NMI)) return PRIO_NMI;
    if (n == int'(EXC_HARD)) return PRIO_HARD;
    return $signed({2'b00, p});
  endfunction : eff_of

  function automatic logic signed [5:0] grp_of(input logic signed [5:0] p, input logic [2:0] sub);
    if (p < 0) return p;
    return p >>> sub;
  endfunction : grp_of

  function automatic logic reg_hit(input logic [7:0] a);
    if (a == A_TBASE) return 1'b1;
    else if (a == A_CFG) return 1'b1;
    else if (a == A_STAT) return 1'b1;
    else if (a == A_SETP) return 1'b1;
    else if (a == A_CLRP) return 1'b1;
    else if (a == A_EN) return 1'b1;
    else if (a == A_PRIO) return 1'b1;
    else if (a == A_QUERY) return 1'b1;
    else return 1'b0;
  endfunction : reg_hit

  function automatic exc_state_t state_of(input logic p, input logic a);
    case ({a, p})
      2'b01:   return EX_PENDING;
      2'b11:   return EX_ACT_PEND;
      2'b10:   return EX_ACTIVE;
      default: return EX_INACTIVE;
    endcase
  endfunction : state_of

  ////////////////////////////////////////////////////////////////////////////
  // winner and current running priority
  always_comb begin
    best      = PRIO_IDLE;
    win_found = 1'b0;
    win_num   = '0;
    cur_grp   = PRIO_IDLE;
    any_act   = 1'b0;
    e         = '0;
    for (int i = NUM_EXC - 1; i > 0; i--) begin
      e = eff_of(i, prio_r[i]);
      if (pend_r[i] && en_r[i] && (!win_found || e <= best)) begin
        best      = e;
        win_found = 1'b1;
        win_num   = 7'(i);
      end
      if (act_r[i] && grp_of(e, cfg_r[2:0]) < cur_grp) begin
        cur_grp = grp_of(e, cfg_r[2:0]);
      end
      any_act = any_act | act_r[i];
    end
    win_grp = grp_of(best, cfg_r[2:0]);
    preempt = win_found && (!any_act || win_grp < cur_grp);
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronous faults; a fault that cannot run escalates
  assign mm_raise  = faults.execute_never | faults.prot_viol;
  assign bus_raise = faults.bus_precise | faults.bus_imprecise;
  assign us_raise  = faults.undef_instr | faults.unal_illegal | faults.bad_state
                   | faults.bad_return | (faults.unal_access & cfg_r[CFG_UNAL])
                   | (faults.div_zero & cfg_r[CFG_DIV]);

  function automatic logic can_run(input logic [6:0] n, input logic enb, input logic [3:0] p,
                                   input logic aa, input logic signed [5:0] cg, input logic [2:0] s);
    return enb && (!aa || grp_of(eff_of(int'(n), p), s) < cg);
  endfunction : can_run

  // set and clear vectors
  always_comb begin
    set_v = '0;
    clr_v = '0;
    set_v[IRQ_BASE +: NUM_IRQ] = irq_lines;
    set_v[EXC_NMI]     = nmi_req;
    set_v[EXC_SYSTICK] = systick_zero;
    set_v[EXC_HARD]    = faults.entry_error;
    if (mm_raise) begin
      if (can_run(EXC_MEM, en_r[EXC_MEM], prio_r[EXC_MEM], any_act, cur_grp, cfg_r[2:0])) set_v[EXC_MEM] = 1'b1;
      else set_v[EXC_HARD] = 1'b1;
    end
    if (bus_raise) begin
      if (can_run(EXC_BUS, en_r[EXC_BUS], prio_r[EXC_BUS], any_act, cur_grp, cfg_r[2:0])) set_v[EXC_BUS] = 1'b1;
      else set_v[EXC_HARD] = 1'b1;
    end
    if (us_raise) begin
      if (can_run(EXC_USAGE, en_r[EXC_USAGE], prio_r[EXC_USAGE], any_act, cur_grp, cfg_r[2:0]))
        set_v[EXC_USAGE] = 1'b1;
      else set_v[EXC_HARD] = 1'b1;
    end
    if (faults.supervisor_call_instruction) begin
      if (can_run(EXC_SUPV, en_r[EXC_SUPV], prio_r[EXC_SUPV], any_act, cur_grp, cfg_r[2:0]))
        set_v[EXC_SUPV] = 1'b1;
      else set_v[EXC_HARD] = 1'b1;
    end
    if (wr_ok && awaddr_r == A_SETP && wdata_r[6:0] != EXC_RESET && int'(wdata_r[6:0]) < NUM_EXC) begin
      set_v[wdata_r[6:0]] = 1'b1;
    end
    if (wr_ok && awaddr_r == A_CLRP && int'(wdata_r[6:0]) < NUM_EXC) clr_v[wdata_r[6:0]] = 1'b1;
    set_v = set_v & EXC_VALID;
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry and return decode
  generate
    for (genvar g = 0; g < NUM_EXC; g++) begin : g_dec
      assign ack_v[g] = ce && entry_ack && pipe_r.req && pipe_r.num == 7'(g);
      assign ret_v[g] = ce && return_valid && return_num == 7'(g);
    end
  endgenerate

  // pending bits, a new request wins over any clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_r <= '0;
      pend_r[EXC_RESET] <= 1'b1;
    end else if (ce) begin
      pend_r <= set_v | (pend_r & ~(clr_v | ack_v));
    end
  end

  // active bits; reset entry never goes active, so the core stays in thread mode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      act_r <= '0;
    end else if (ce) begin
      act_r <= ((ack_v & ~84'(2)) | (act_r & ~ret_v)) & EXC_VALID;
    end
  end

  // halt until the reset vector is taken
  always_ff @(posedge clk) begin
    if (!rstn) begin
      halt_r <= 1'b1;
    end else if (ce && ack_v[EXC_RESET]) begin
      halt_r <= 1'b0;
    end
  end

  // registered pipeline request, one cycle after the decision
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pipe_r.req        <= 1'b1;
      pipe_r.num        <= EXC_RESET;
      pipe_r.vector     <= VEC_RESET;
      pipe_r.table_base <= TBASE_RESET;
    end else if (ce) begin
      pipe_r.req        <= preempt && !(entry_ack && pipe_r.req && pipe_r.num == win_num);
      pipe_r.num        <= win_num;
      pipe_r.vector     <= tbase_r + {23'h0, win_num, 2'b00};
      pipe_r.table_base <= tbase_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tbase_r <= TBASE_RESET;
    end else if (ce && wr_ok && awaddr_r == A_TBASE) begin
      tbase_r <= wdata_r & TBASE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_r <= CFG_RESET;
    end else if (ce && wr_ok && awaddr_r == A_CFG) begin
      cfg_r <= wdata_r[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_r <= '0;
    end else if (ce && wr_ok && awaddr_r == A_QUERY) begin
      sel_r <= wdata_r[6:0];
    end
  end

  // enables; fixed-priority exceptions stay on
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_r <= EN_RESET;
    end else if (ce && wr_ok && awaddr_r == A_EN && wdata_r[6:0] > EXC_HARD
                 && int'(wdata_r[6:0]) < NUM_EXC) begin
      en_r[wdata_r[6:0]] <= wdata_r[EN_BIT];
    end
  end

  // configurable priorities
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_EXC; i++) prio_r[i] <= '0;
    end else if (ce && wr_ok && awaddr_r == A_PRIO && wdata_r[6:0] > EXC_HARD
                 && int'(wdata_r[6:0]) < NUM_EXC) begin
      prio_r[wdata_r[6:0]] <= wdata_r[PRIO_LSB +: PRIO_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready  = !w_hold_r && !bvalid_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_ok   = wr_fire && reg_hit(awaddr_r) && wstrb_r == 4'hf;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  assign arready = !rvalid_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_r <= 1'b1;
        rresp_r  <= reg_hit({araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
        if (araddr[7:2] == A_TBASE[7:2]) rdata_r <= tbase_r;
        else if (araddr[7:2] == A_CFG[7:2]) rdata_r <= {27'h0, cfg_r};
        else if (araddr[7:2] == A_STAT[7:2]) rdata_r <= {8'h0, 1'b0, pipe_r.num, 6'h0, halt_r, any_act,
                                                         1'b0, win_num};
        else if (araddr[7:2] == A_QUERY[7:2] && int'(sel_r) < NUM_EXC)
          rdata_r <= {16'h0, prio_r[sel_r], 1'b0, en_r[sel_r], state_of(pend_r[sel_r], act_r[sel_r]),
                      1'b0, sel_r};
        else rdata_r <= '0;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // outputs
  assign pipe        = pipe_r;
  assign halt        = halt_r;
  assign thread_priv = !any_act && !halt_r;
  assign bvalid      = bvalid_r;
  assign bresp       = bresp_r;
  assign rvalid      = rvalid_r;
  assign rdata       = rdata_r;
  assign rresp       = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_ack_active: assert property (@(posedge clk) disable iff (!rstn)
    ce && entry_ack && pipe_r.req && pipe_r.num > EXC_HARD && !return_valid |=> act_r[$past(pipe_r.num)])
    else $error("taken exception not active");
  chk_irq_pend: assert property (@(posedge clk) disable iff (!rstn)
    ce && irq_lines[0] |=> pend_r[IRQ_BASE])
    else $error("irq line did not pend");
  chk_reset_entry: assert property (@(posedge clk)
    !rstn |=> halt_r && pipe_r.req && pipe_r.num == EXC_RESET && pipe_r.vector == VEC_RESET)
    else $error("reset does not fetch reset vector");
  chk_nmi_wins: assert property (@(posedge clk) disable iff (!rstn)
    pend_r[EXC_NMI] && !pend_r[EXC_RESET] |-> win_num == EXC_NMI && (preempt || act_r[EXC_NMI]))
    else $error("nmi not selected");
  chk_entry_error: assert property (@(posedge clk) disable iff (!rstn)
    ce && faults.entry_error |=> pend_r[EXC_HARD])
    else $error("entry error did not pend hard fault");
  chk_exec_never: assert property (@(posedge clk) disable iff (!rstn)
    ce && faults.execute_never |=> pend_r[EXC_MEM] || pend_r[EXC_HARD])
    else $error("execute-never fetch not faulted");
  chk_supv_pend: assert property (@(posedge clk) disable iff (!rstn)
    ce && faults.supervisor_call_instruction |=> pend_r[EXC_SUPV] || pend_r[EXC_HARD])
    else $error("supervisor call not pended");
  chk_vector_addr: assert property (@(posedge clk) disable iff (!rstn)
    ce && $past(ce) && pipe_r.req |-> pipe_r.vector == $past(tbase_r) + {23'h0, pipe_r.num, 2'b00})
    else $error("vector address wrong");
  chk_tbase_range: assert property (@(posedge clk) disable iff (!rstn)
    ce && $past(ce) |-> pipe_r.table_base == $past(tbase_r) && (tbase_r & ~TBASE_MASK) == 32'h0)
    else $error("table base outside range");
  chk_no_equal_preempt: assert property (@(posedge clk) disable iff (!rstn)
    any_act && win_found && win_grp >= cur_grp |=> !pipe_r.req || !$past(ce))
    else $error("equal priority preempted");
  cov_nested: cover property (@(posedge clk) disable iff (!rstn) $countones(act_r) >= 2);
  cov_act_pend: cover property (@(posedge clk) disable iff (!rstn) (act_r & pend_r) != '0);
  cov_escalate: cover property (@(posedge clk) disable iff (!rstn) mm_raise && !en_r[EXC_MEM]);
  cov_reset_taken: cover property (@(posedge clk) disable iff (!rstn) $fell(halt_r));
endmodule : exc_ctrl

// [design/exc_pkg.sv]
// Purpose: shared constants and types for the exception priority and vector unit
// Assumes: 32-bit AXI4-Lite register access, 100 MHz core clock
// Notes:   exception numbers 1..83, peripheral lines map to 16..83
package exc_pkg;
  // exception numbering
  localparam int NUM_EXC  = 84;
  localparam int NUM_IRQ  = 68;
  localparam int IRQ_BASE = 16;
  localparam int EXC_W    = 7;
  localparam int PRIO_W   = 4;
  localparam logic [6:0] EXC_RESET   = 7'h01;
  localparam logic [6:0] EXC_NMI     = 7'h02;
  localparam logic [6:0] EXC_HARD    = 7'h03;
  localparam logic [6:0] EXC_MEM     = 7'h04;
  localparam logic [6:0] EXC_BUS     = 7'h05;
  localparam logic [6:0] EXC_USAGE   = 7'h06;
  localparam logic [6:0] EXC_SUPV    = 7'h0b;
  localparam logic [6:0] EXC_PENDSRV = 7'h0e;
  localparam logic [6:0] EXC_SYSTICK = 7'h0f;
  // fixed priorities, configurable ones sit above them
  localparam logic signed [5:0] PRIO_RESET = -6'sd3;
  localparam logic signed [5:0] PRIO_NMI   = -6'sd2;
  localparam logic signed [5:0] PRIO_HARD  = -6'sd1;
  localparam logic signed [5:0] PRIO_IDLE  = 6'sd31;
  // implemented numbers and enables after reset
  localparam logic [83:0] EXC_VALID = 84'hf_ffff_ffff_ffff_ffff_c87e;
  localparam logic [83:0] EN_RESET  = 84'h0_0000_0000_0000_0000_c80e;
  // vector table
  localparam logic [31:0] TBASE_RESET = 32'h0000_0000;
  localparam logic [31:0] TBASE_MASK  = 32'h3fff_ff80;
  localparam logic [31:0] VEC_RESET  = 32'h0000_0004;
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_TBASE = 8'h00;
  localparam logic [7:0] A_CFG   = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_SETP  = 8'h0c;
  localparam logic [7:0] A_CLRP  = 8'h10;
  localparam logic [7:0] A_EN    = 8'h14;
  localparam logic [7:0] A_PRIO  = 8'h18;
  localparam logic [7:0] A_QUERY = 8'h1c;
  localparam int CFG_SUB_LSB = 0;
  localparam int CFG_UNAL    = 3;
  localparam int CFG_DIV     = 4;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam int EN_BIT      = 8;
  localparam int PRIO_LSB    = 8;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // per-exception state, gray order along entry and return
  typedef enum logic [1:0] {
    EX_INACTIVE = 2'b00,
    EX_PENDING  = 2'b01,
    EX_ACT_PEND = 2'b11,
    EX_ACTIVE   = 2'b10
  } exc_state_t;

  // fault and trap events from the pipeline
  typedef struct packed {
    logic execute_never;
    logic prot_viol;
    logic bus_precise;
    logic bus_imprecise;
    logic undef_instr;
    logic unal_illegal;
    logic bad_state;
    logic bad_return;
    logic unal_access;
    logic div_zero;
    logic supervisor_call_instruction;
    logic entry_error;
  } fault_in_t;

  // request toward the pipeline
  typedef struct packed {
    logic        req;
    logic [6:0]  num;
    logic [31:0] vector;
    logic [31:0] table_base;
  } pipe_out_t;
endpackage : exc_pkg

// [testbench/pipe_model.sv]
// Purpose: pipeline stand-in that takes the offered exception
// Assumes: go pulses from the bench ask for one entry
// Notes:   acknowledge only while the request flag is up
`timescale 1ns/1ps
module pipe_model (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               go,
  input  wire exc_pkg::pipe_out_t pipe,
  output logic                    entry_ack,
  output logic [31:0]             handler
);
  import exc_pkg::*;
  ////////////////////////////////////////////////////////////////
  // one-cycle acknowledge, never without a request
  always_ff @(posedge clk) begin
    entry_ack <= rstn & go & pipe.req;
  end

  // handler taken from the taken entry's vector address with bit 0 forced set
  always_ff @(posedge clk) begin
    if (!rstn) begin
      handler <= '0;
    end else if (entry_ack && pipe.req) begin
      handler <= {pipe.vector[31:1], 1'b1};
    end
  end
endmodule : pipe_model

// [testbench/testbench.sv]
// Purpose: register and pipeline sequences against the exception unit
// Assumes: clock enable high except for one low cycle, bready and rready always high
// Notes:   pipe fields checked a few cycles after the irq, supervisor call, nmi and entry error pulses
`timescale 1ns/1ps
module testbench;
  import exc_pkg::*;
  logic               clk, rstn, ce, go, nmi_req, systick_zero, return_valid, halt, thread_priv;
  logic [NUM_IRQ-1:0] irq_lines;
  fault_in_t          faults;
  logic [6:0]         return_num;
  pipe_out_t          pipe;
  logic               entry_ack, awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata, rv, handler;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, br, rr;
  int                 num_errors, total_checks;
  ////////////////////////////////////////////////////////////////
  // clock and instances
  always #5 clk = ~clk;
  exc_ctrl dut_u (.clk(clk), .rstn(rstn), .ce(ce), .irq_lines(irq_lines), .nmi_req(nmi_req),
    .systick_zero(systick_zero), .faults(faults), .entry_ack(entry_ack), .return_valid(return_valid),
    .return_num(return_num), .pipe(pipe), .halt(halt), .thread_priv(thread_priv), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  pipe_model pm_u (.clk(clk), .rstn(rstn), .go(go), .pipe(pipe), .entry_ack(entry_ack), .handler(handler));
  ////////////////////////////////////////////////////////////////
  // verdict and compare
  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task automatic to(input int n);
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
  endtask : to
  ////////////////////////////////////////////////////////////////
  // axi4-lite master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    int   n;
    ta = 0;
    tw = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50 && !(ta && tw); n++) begin
      @(posedge clk);
      if (!ta && awready) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    to(n);
    for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge clk);
    to(n);
    br = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta;
    int   n;
    ta = 0;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50 && !ta; n++) begin
      @(posedge clk);
      ta = arready;
    end
    arvalid <= 1'b0;
    to(n);
    for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(posedge clk);
    to(n);
    rv = rdata;
    rr = rresp;
  endtask : rd
  // select a number, then read its state word
  task automatic q(input logic [6:0] n);
    wr(A_QUERY, {25'h0, n});
    rd(A_QUERY);
  endtask : q
  task automatic ack();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ack
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {clk, rstn, go, nmi_req, systick_zero, return_valid, awvalid, wvalid, arvalid} = '0;
    {irq_lines, faults, return_num, awaddr, araddr, wdata} = '0;
    {ce, bready, rready, wstrb} = 7'h7f;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp("req", 1, pipe.req);
    cmp("num", EXC_RESET, pipe.num);
    cmp("vector", VEC_RESET, pipe.vector);
    cmp("base", TBASE_RESET, pipe.table_base);
    cmp("halt", 1, halt);
    ack();
    cmp("halt", 0, halt);
    cmp("thread_priv", 1, thread_priv);
    cmp("req", 0, pipe.req);
    q(16);
    cmp("prio", 0, rv[15:12]);
    cmp("state", EX_INACTIVE, rv[9:8]);
    wr(A_EN, 32'h0000_0002);
    q(2);
    cmp("en", 1, rv[10]);
    wr(A_TBASE, 32'hffff_ffff);
    rd(A_TBASE);
    cmp("tbase", TBASE_MASK, rv);
    wr(A_EN, 32'h0000_0110);
    wr(A_EN, 32'h0000_0111);
    irq_lines <= 68'h3;
    @(posedge clk);
    irq_lines <= '0;
    repeat (3) @(posedge clk);
    cmp("num", 16, pipe.num);
    cmp("vector", 32'h3fff_ffc0, pipe.vector);
    cmp("req", 1, pipe.req);
    cmp("base", TBASE_MASK, pipe.table_base);
    wr(A_PRIO, 32'h0000_0510);
    wr(A_PRIO, 32'h0000_0211);
    repeat (2) @(posedge clk);
    cmp("num", 17, pipe.num);
    ack();
    cmp("handler", 32'h3fff_ffc5, handler);
    q(17);
    cmp("state", EX_ACTIVE, rv[9:8]);
    cmp("req", 0, pipe.req);
    wr(A_PRIO, 32'h0000_0210);
    repeat (2) @(posedge clk);
    cmp("req", 0, pipe.req);
    cmp("num", 16, pipe.num);
    wr(A_PRIO, 32'h0000_0f10);
    q(16);
    cmp("prio", 15, rv[15:12]);
    cmp("state", EX_PENDING, rv[9:8]);
    wr(A_SETP, 32'h0000_0011);
    q(17);
    cmp("state", EX_ACT_PEND, rv[9:8]);
    faults.supervisor_call_instruction <= 1'b1;
    @(posedge clk);
    faults <= '0;
    repeat (3) @(posedge clk);
    cmp("num", EXC_SUPV, pipe.num);
    cmp("req", 1, pipe.req);
    nmi_req <= 1'b1;
    @(posedge clk);
    nmi_req <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("num", EXC_NMI, pipe.num);
    rd(A_STAT);
    cmp("status", 32'h0002_0102, rv);
    faults.entry_error <= 1'b1;
    @(posedge clk);
    faults <= '0;
    q(3);
    cmp("state", EX_PENDING, rv[9:8]);
    cmp("num", EXC_NMI, pipe.num);
    systick_zero <= 1'b1;
    @(posedge clk);
    systick_zero <= 1'b0;
    q(15);
    cmp("state", EX_PENDING, rv[9:8]);
    return_num <= 7'h11;
    return_valid <= 1'b1;
    @(posedge clk);
    return_valid <= 1'b0;
    q(17);
    cmp("state", EX_PENDING, rv[9:8]);
    // usage traps: divide-by-zero only once configured, disabled memory fault escalates
    wr(A_EN, 32'h0000_0106);
    faults <= '{div_zero: 1'b1, default: 1'b0};
    @(posedge clk);
    faults <= '0;
    q(6);
    cmp("state", EX_INACTIVE, rv[9:8]);
    wr(A_CFG, 32'h0000_0012);
    rd(A_CFG);
    cmp("cfg", 32'h0000_0012, rv);
    faults <= '{execute_never: 1'b1, div_zero: 1'b1, default: 1'b0};
    @(posedge clk);
    faults <= '0;
    q(6);
    cmp("state", EX_PENDING, rv[9:8]);
    q(4);
    cmp("state", EX_INACTIVE, rv[9:8]);
    // a request while the clock enable is low is not seen
    ce <= 1'b0;
    irq_lines <= 68'h4;
    @(posedge clk);
    ce <= 1'b1;
    irq_lines <= '0;
    q(18);
    cmp("state", EX_INACTIVE, rv[9:8]);
    wr(8'hf0, 32'h0);
    cmp("bresp", RESP_SLVERR, br);
    rd(8'hf0);
    cmp("rresp", RESP_SLVERR, rr);
    cmp("rdata", 0, rv);
    // warm reset in mid-run restores base, halt and priorities
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp("base", TBASE_RESET, pipe.table_base);
    cmp("num", EXC_RESET, pipe.num);
    cmp("halt", 1, halt);
    q(16);
    cmp("prio", 0, rv[15:12]);
    stop_test();
  end
endmodule : testbench
